// ### verilog/ddac_pkg.sv
// Constants shared by the two-channel DAC control block.
// Assumes a 32-bit APB master and a 40 MHz ref_clk.
package ddac_pkg;
    localparam int unsigned ADDR_W = 8;
    localparam int unsigned APB_DW = 32;
    localparam int unsigned NUM_CH = 2;

    // Register byte offsets
    localparam logic [ADDR_W-1:0] OFF_MODE = 8'h00;
    localparam logic [ADDR_W-1:0] OFF_MODE_SET = 8'h04;
    localparam logic [ADDR_W-1:0] OFF_MODE_CLR = 8'h08;
    localparam logic [ADDR_W-1:0] OFF_VAL0 = 8'h0c;
    localparam logic [ADDR_W-1:0] OFF_VAL1 = 8'h10;
    localparam logic [ADDR_W-1:0] OFF_STATUS = 8'h14;

    // Mode register fields
    localparam int unsigned MODE_MD0_BIT = 0;
    localparam int unsigned MODE_MD1_BIT = 1;
    localparam int unsigned MODE_CE0_BIT = 4;
    localparam int unsigned MODE_CE1_BIT = 5;
    localparam logic [7:0] MODE_IMPL_MASK = 8'h33;
    localparam logic [7:0] MODE_RESET = 8'h00;
    localparam logic [7:0] VALUE_RESET = 8'h00;

    // Status register fields
    localparam int unsigned STAT_BUSY0_BIT = 0;
    localparam int unsigned STAT_BUSY1_BIT = 1;

    // Settling time after each output update
    localparam int unsigned CLK_PERIOD_NS = 25;
    localparam int unsigned CONV_TIME_NS = 3000;
    localparam int unsigned CONV_CYCLES = (CONV_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned CONV_CNT_W = $clog2(CONV_CYCLES + 1);

    typedef enum logic {
        DDAC_IDLE,
        DDAC_SETTLE
    } ddac_conv_t;
endpackage : ddac_pkg

// ### verilog/ddac_top.sv
// Control logic of a two-channel 8-bit DAC: mode register, value registers,
// output code latches with normal and timer-triggered update.
// Assumes an APB master on ref_clk and timer compare events as one-cycle pulses
// synchronous to ref_clk; the resistor ladder sits outside and reads dac_code_*.
`timescale 1ns/100ps

// Summary of operation
// - Two independent channels, each with 8-bit code
// - Output code equals stored value m, 0..255
// - Mode register byte and single-bit access
// - Reset clears mode register to zero
// - Per-channel enable bit gates channel operation
// - Per-channel mode bit: normal or real-time
// - Real-time update on timer2/timer3 compare event
// - Normal mode: write updates, value held otherwise
// - Real-time: stored value output at each event
// - Value registers byte access, reset to zero
module ddac_top
    import ddac_pkg::*;
#(
    parameter int unsigned CODE_W = 8
) (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [APB_DW-1:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [APB_DW-1:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic timer2_compare_event,
    input wire logic timer3_compare_event,
    output logic [CODE_W-1:0] dac_code_ch0,
    output logic [CODE_W-1:0] dac_code_ch1,
    output logic dac_active_ch0,
    output logic dac_active_ch1,
    output logic dac_update_ch0,
    output logic dac_update_ch1
);

    if (CODE_W < 1 || CODE_W > 8) begin : g_bad_code_w
        $error("ddac_top: CODE_W must be 1 to 8");
    end

    function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] off);
        return a == off;
    endfunction : hit

    function automatic logic mapped(input logic [ADDR_W-1:0] a);
        return hit(a, OFF_MODE) || hit(a, OFF_MODE_SET) || hit(a, OFF_MODE_CLR) ||
               hit(a, OFF_VAL0) || hit(a, OFF_VAL1) || hit(a, OFF_STATUS);
    endfunction : mapped

    logic [7:0] mode;
    logic [7:0] next_mode;
    logic [CODE_W-1:0] value [NUM_CH];
    logic [CODE_W-1:0] next_value [NUM_CH];
    logic [CODE_W-1:0] code [NUM_CH];
    logic [CODE_W-1:0] src [NUM_CH];
    logic [NUM_CH-1:0] ce;
    logic [NUM_CH-1:0] ce_q;
    logic [NUM_CH-1:0] md;
    logic [NUM_CH-1:0] trig;
    logic [NUM_CH-1:0] wr_val;
    logic [NUM_CH-1:0] load;
    logic [NUM_CH-1:0] upd;
    logic [NUM_CH-1:0] busy;
    ddac_conv_t conv_st [NUM_CH];
    logic [CONV_CNT_W-1:0] conv_cnt [NUM_CH];
    logic wr_en;
    logic rd_setup;
    logic [APB_DW-1:0] rd_mux;

    // Writes land only at the access edge; lane 0 carries every register
    assign wr_en = psel && penable && pwrite && pstrb[0];
    assign rd_setup = psel && !penable;
    assign pready = 1'b1;

    assign ce[0] = mode[MODE_CE0_BIT];
    assign ce[1] = mode[MODE_CE1_BIT];
    assign md[0] = mode[MODE_MD0_BIT];
    assign md[1] = mode[MODE_MD1_BIT];
    assign trig[0] = timer2_compare_event;
    assign trig[1] = timer3_compare_event;
    assign wr_val[0] = wr_en && hit(paddr, OFF_VAL0);
    assign wr_val[1] = wr_en && hit(paddr, OFF_VAL1);

    // Mode register: whole byte, or set/clear of chosen bits
    always_comb begin
        next_mode = mode;
        if (wr_en && hit(paddr, OFF_MODE)) begin
            next_mode = pwdata[7:0] & MODE_IMPL_MASK;
        end else if (wr_en && hit(paddr, OFF_MODE_SET)) begin
            next_mode = mode | (pwdata[7:0] & MODE_IMPL_MASK);
        end else if (wr_en && hit(paddr, OFF_MODE_CLR)) begin
            next_mode = mode & ~pwdata[7:0];
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            mode <= MODE_RESET;
        end else begin
            mode <= next_mode;
        end
    end

    always_comb begin
        for (int i = 0; i < NUM_CH; i++) begin
            next_value[i] = wr_val[i] ? pwdata[CODE_W-1:0] : value[i];
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            for (int i = 0; i < NUM_CH; i++) begin
                value[i] <= VALUE_RESET[CODE_W-1:0];
            end
        end else begin
            for (int i = 0; i < NUM_CH; i++) begin
                value[i] <= next_value[i];
            end
        end
    end

    // A timer event that meets a software write takes the older stored value
    always_comb begin
        for (int i = 0; i < NUM_CH; i++) begin
            src[i] = md[i] ? value[i] : next_value[i];
            load[i] = ce[i] && (md[i] ? trig[i]
                                      : (wr_val[i] || !ce_q[i]));
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            ce_q <= '0;
        end else begin
            ce_q <= ce;
        end
    end

    // Output code latches, one per channel, each steered only by its own bits
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            for (int i = 0; i < NUM_CH; i++) begin
                code[i] <= '0;
            end
            upd <= '0;
        end else begin
            for (int i = 0; i < NUM_CH; i++) begin
                if (!ce[i]) begin
                    code[i] <= '0;
                end else if (load[i]) begin
                    code[i] <= src[i];
                end
            end
            upd <= load;
        end
    end

    // Settling window; status only, the registers stay writable meanwhile
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            for (int i = 0; i < NUM_CH; i++) begin
                conv_st[i] <= DDAC_IDLE;
                conv_cnt[i] <= '0;
            end
        end else begin
            for (int i = 0; i < NUM_CH; i++) begin
                if (!ce[i]) begin
                    conv_st[i] <= DDAC_IDLE;
                    conv_cnt[i] <= '0;
                end else if (load[i]) begin
                    conv_st[i] <= DDAC_SETTLE;
                    conv_cnt[i] <= CONV_CNT_W'(CONV_CYCLES - 1);
                end else begin
                    unique case (conv_st[i])
                        DDAC_IDLE: begin
                            conv_cnt[i] <= '0;
                        end
                        DDAC_SETTLE: begin
                            if (conv_cnt[i] == '0) begin
                                conv_st[i] <= DDAC_IDLE;
                            end else begin
                                conv_cnt[i] <= conv_cnt[i] - 1'b1;
                            end
                        end
                    endcase
                end
            end
        end
    end

    always_comb begin
        for (int i = 0; i < NUM_CH; i++) begin
            busy[i] = (conv_st[i] == DDAC_SETTLE);
        end
    end

    always_comb begin
        rd_mux = '0;
        if (hit(paddr, OFF_MODE) || hit(paddr, OFF_MODE_SET) || hit(paddr, OFF_MODE_CLR)) begin
            rd_mux[7:0] = mode;
        end else if (hit(paddr, OFF_VAL0)) begin
            rd_mux[CODE_W-1:0] = value[0];
        end else if (hit(paddr, OFF_VAL1)) begin
            rd_mux[CODE_W-1:0] = value[1];
        end else if (hit(paddr, OFF_STATUS)) begin
            rd_mux[STAT_BUSY0_BIT] = busy[0];
            rd_mux[STAT_BUSY1_BIT] = busy[1];
        end
    end

    // Read data and error are captured in the setup cycle, so both come from flops
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            prdata <= '0;
            pslverr <= 1'b0;
        end else if (rd_setup) begin
            prdata <= pwrite ? '0 : rd_mux;
            pslverr <= !mapped(paddr);
        end
    end

    assign dac_code_ch0 = code[0];
    assign dac_code_ch1 = code[1];
    assign dac_active_ch0 = ce_q[0];
    assign dac_active_ch1 = ce_q[1];
    assign dac_update_ch0 = upd[0];
    assign dac_update_ch1 = upd[1];

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);

    property p_ch_indep;
        (ce[1] && !load[1]) |=> (dac_code_ch1 == $past(dac_code_ch1));
    endproperty
    a_ch_indep: assert property (p_ch_indep) else $error("ch1 code moved without own load");

    property p_code_tracks;
        (ce[0] && !md[0]) ##1 (ce[0] && !md[0]) |-> (dac_code_ch0 == value[0]);
    endproperty
    a_code_tracks: assert property (p_code_tracks) else $error("ch0 code differs from value");

    property p_mode_set;
        (wr_en && hit(paddr, OFF_MODE_SET))
            |=> (mode == ($past(mode) | ($past(pwdata[7:0]) & MODE_IMPL_MASK)));
    endproperty
    a_mode_set: assert property (p_mode_set) else $error("bit set of mode failed");

    property p_mode_reset;
        @(posedge ref_clk) disable iff (1'b0) !rst_n |=> (mode == MODE_RESET && code[0] == '0);
    endproperty
    a_mode_reset: assert property (p_mode_reset) else $error("reset left mode nonzero");

    property p_disabled;
        !ce[1] |=> (dac_code_ch1 == '0 && !dac_update_ch1);
    endproperty
    a_disabled: assert property (p_disabled) else $error("disabled ch1 still active");

    property p_rt_ignores_write;
        (ce[0] && md[0] && wr_val[0] && !trig[0]) |=> !dac_update_ch0 && $stable(dac_code_ch0);
    endproperty
    a_rt_ignores_write: assert property (p_rt_ignores_write) else $error("rt ch0 moved on write");

    property p_rt_trigger;
        (ce[1] && md[1] && timer3_compare_event) |=> dac_update_ch1 ##1 busy[1];
    endproperty
    a_rt_trigger: assert property (p_rt_trigger) else $error("timer3 event did not update ch1");

    property p_normal_write;
        (ce[1] && !md[1] && wr_val[1] && ce_q[1])
            |=> (dac_code_ch1 == $past(pwdata[CODE_W-1:0])) ##1 $stable(dac_code_ch1) || upd[1];
    endproperty
    a_normal_write: assert property (p_normal_write) else $error("normal write not output");

    property p_rt_value;
        (ce[0] && md[0] && timer2_compare_event) |=> (dac_code_ch0 == $past(value[0]));
    endproperty
    a_rt_value: assert property (p_rt_value) else $error("event output wrong value");

    property p_value_write;
        wr_val[1] |=> (value[1] == $past(pwdata[CODE_W-1:0]));
    endproperty
    a_value_write: assert property (p_value_write) else $error("value1 write lost");

    property p_enable_load;
        (ce[0] && !md[0] && !ce_q[0] && !wr_val[0]) |=> (dac_code_ch0 == $past(value[0]));
    endproperty
    a_enable_load: assert property (p_enable_load) else $error("enable lost ch0 value");

    property p_rt_value_ch1;
        (ce[1] && md[1] && timer3_compare_event) |=> (dac_code_ch1 == $past(value[1]));
    endproperty
    a_rt_value_ch1: assert property (p_rt_value_ch1) else $error("bad ch1 event value");

    property p_disabled_ch0;
        !ce[0] |=> (dac_code_ch0 == '0 && !dac_update_ch0);
    endproperty
    a_disabled_ch0: assert property (p_disabled_ch0) else $error("disabled ch0 active");

endmodule : ddac_top

// ### test/ddac_timer_model.sv
// Timer side partner: emits one-cycle compare events for the DAC block.
// Assumes the bench pulses req for one cycle; the event follows delay+1 cycles after the edge that samples req.
`timescale 1ns/100ps
module ddac_timer_model (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic [1:0] req,
    input wire logic [7:0] delay,
    output logic timer2_compare_event,
    output logic timer3_compare_event
);
    logic [1:0] pend;
    logic [1:0] ev;
    logic [7:0] cnt;

    // A long delay models a slow timer, zero a prompt one
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            pend <= 2'h0;
            cnt <= 8'h00;
            ev <= 2'h0;
        end else begin
            ev <= 2'h0;
            if (req != 2'h0) begin
                pend <= req;
                cnt <= delay;
            end else if (pend != 2'h0) begin
                if (cnt == 8'h00) begin
                    ev <= pend;
                    pend <= 2'h0;
                end else begin
                    cnt <= cnt - 8'h01;
                end
            end
        end
    end

    assign timer2_compare_event = ev[0];
    assign timer3_compare_event = ev[1];
endmodule : ddac_timer_model

// ### test/dual_dac_control_tb_top.sv
// Self-checking bench for the two-channel DAC control block.
// Assumes an APB slave on ref_clk and a timer model on the event inputs.
`timescale 1ns/100ps
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin num_errors++; \
    $display("unexpected at %0t: got %h want %h", $time, g, e); end end
module dual_dac_control_tb_top;
    import ddac_pkg::*;
    logic ref_clk = 1'b0;
    logic rst_n = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready, pslverr;
    logic t2, t3;
    logic [1:0] tm_req = 2'h0;
    logic [7:0] tm_dly = 8'h00;
    logic [7:0] code0, code1;
    logic act0, act1;
    logic upd0, upd1;
    logic [3:0] pstrb = 4'hf;
    logic [7:0] n_upd0 = 8'h00;
    logic [7:0] n_upd1 = 8'h00;
    int num_errors = 0;
    int n_tests = 0;
    int cycles = 0;
    localparam logic [31:0] MD0 = 32'h1 << MODE_MD0_BIT;
    localparam logic [31:0] CE0 = 32'h1 << MODE_CE0_BIT;
    localparam logic [31:0] CE1 = 32'h1 << MODE_CE1_BIT;

    ddac_top i_ddac_top (.ref_clk(ref_clk), .rst_n(rst_n), .paddr(paddr), .psel(psel),
        .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .timer2_compare_event(t2),
        .timer3_compare_event(t3), .dac_code_ch0(code0), .dac_code_ch1(code1),
        .dac_active_ch0(act0), .dac_active_ch1(act1), .dac_update_ch0(upd0),
        .dac_update_ch1(upd1));
    ddac_timer_model i_ddac_timer_model (.ref_clk(ref_clk), .rst_n(rst_n), .req(tm_req),
        .delay(tm_dly), .timer2_compare_event(t2), .timer3_compare_event(t3));

    initial begin
        forever #12.5 ref_clk = ~ref_clk;
    end

    task end_of_test();
        $display("comparisons %0d mismatches %0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : end_of_test

    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 5000) begin
            num_errors++;
            $display("unexpected at %0t: run too long", $time);
            end_of_test();
        end
    end

    // Counts update pulses; an unknown pulse poisons the count so it cannot pass
    always @(posedge ref_clk) begin
        if (rst_n === 1'b1) begin
            n_upd0 <= n_upd0 + 8'(upd0);
            n_upd1 <= n_upd1 + 8'(upd1);
        end
    end

    task cyc(input int n);
        repeat (n) @(posedge ref_clk);
    endtask : cyc

    // Holds the request until pready is seen high at a rising edge
    task apb(input logic [7:0] a, input logic w, input logic [31:0] d,
             output logic [31:0] r, output logic e);
        @(posedge ref_clk);
        paddr <= a;
        pwrite <= w;
        pwdata <= d;
        psel <= 1'b1;
        penable <= 1'b0;
        @(posedge ref_clk);
        penable <= 1'b1;
        do @(posedge ref_clk); while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic e;
        apb(a, 1'b1, d, r, e);
    endtask : wr

    task rd(input logic [7:0] a, input logic [31:0] x, input logic xe);
        logic [31:0] r;
        logic e;
        apb(a, 1'b0, 32'h0, r, e);
        `CHK(r, x)
        `CHK(e, xe)
    endtask : rd

    task fire(input logic [1:0] ch, input logic [7:0] dly);
        @(posedge ref_clk);
        tm_req <= ch;
        tm_dly <= dly;
        @(posedge ref_clk);
        tm_req <= 2'h0;
        cyc(dly + 4);
    endtask : fire

    initial begin
        cyc(12);
        rst_n <= 1'b1;
        rd(OFF_MODE, 32'h0, 1'b0);
        rd(OFF_VAL0, 32'h0, 1'b0);
        rd(OFF_VAL1, 32'h0, 1'b0);
        `CHK(code0, 8'h00)
        $display("test reset done");
        wr(OFF_VAL0, 32'h5a);
        wr(OFF_MODE_SET, CE0);
        cyc(3);
        `CHK(code0, 8'h5a)
        `CHK(act0, 1'b1)
        wr(OFF_VAL0, 32'hff);
        cyc(20);
        `CHK(code0, 8'hff)
        rd(OFF_VAL0, 32'hff, 1'b0);
        $display("test normal done");
        wr(OFF_VAL1, 32'h01);
        wr(OFF_MODE_SET, CE1);
        cyc(3);
        `CHK(code1, 8'h01)
        `CHK(code0, 8'hff)
        `CHK(act1, 1'b1)
        wr(OFF_VAL1, 32'h7e);
        cyc(2);
        `CHK(code1, 8'h7e)
        $display("test channels done");
        wr(OFF_MODE_SET, MD0);
        wr(OFF_VAL0, 32'h33);
        cyc(3);
        `CHK(code0, 8'hff)
        fire(2'b10, 8'h00);
        `CHK(code1, 8'h7e)
        fire(2'b01, 8'h1e);
        `CHK(code0, 8'h33)
        rd(OFF_MODE, CE0 | CE1 | MD0, 1'b0);
        $display("test realtime done");
        wr(OFF_MODE_CLR, CE0);
        cyc(3);
        `CHK(code0, 8'h00)
        rd(OFF_MODE_CLR, CE1 | MD0, 1'b0);
        rd(8'h20, 32'h0, 1'b1);
        wr(OFF_MODE, 32'h33);
        wr(OFF_VAL1, 32'h80);
        cyc(3);
        `CHK(code1, 8'h7e)
        fire(2'b10, 8'h05);
        `CHK(code1, 8'h80)
        rd(OFF_STATUS, 32'h1 << STAT_BUSY1_BIT, 1'b0);
        cyc(CONV_CYCLES);
        rd(OFF_STATUS, 32'h0, 1'b0);
        rd(OFF_MODE, 32'h33, 1'b0);
        pstrb <= 4'h0;
        wr(OFF_VAL0, 32'h11);
        pstrb <= 4'hf;
        rd(OFF_VAL0, 32'h33, 1'b0);
        `CHK(n_upd0, 8'h03)
        `CHK(n_upd1, 8'h03)
        $display("test mode byte done");
        end_of_test();
    end
endmodule : dual_dac_control_tb_top
